// ===== usfc_pkg.sv
// shared constants, modes and decode helpers for the software flow control block
package usfc_pkg;
	// register indices; byte address is four times the index
	localparam logic [3:0] USFC_IDX_IER = 4'h1;
	localparam logic [3:0] USFC_IDX_FCR = 4'h2;
	localparam logic [3:0] USFC_IDX_LCR = 4'h3;
	localparam logic [3:0] USFC_IDX_RES1 = 4'h4;
	localparam logic [3:0] USFC_IDX_RES2 = 4'h5;
	localparam logic [3:0] USFC_IDX_PAU1 = 4'h6;
	localparam logic [3:0] USFC_IDX_PAU2 = 4'h7;
	localparam logic [3:0] USFC_IDX_EFR = 4'h8;
	localparam logic [3:0] USFC_IDX_MCR = 4'h9;
	localparam logic [3:0] USFC_IDX_ISR = 4'ha;
	localparam logic [3:0] USFC_IDX_IMR = 4'hb;
	localparam logic [3:0] USFC_IDX_STAT = 4'hc;
	localparam int USFC_ADDR_LSB = 2;
	// values after reset and the unlock key
	localparam logic [7:0] USFC_RST_BYTE = 8'h00;
	localparam logic [1:0] USFC_RST_INT = 2'h0;
	localparam logic [7:0] USFC_LCR_KEY = 8'hbf;
	// field positions
	localparam int USFC_EFR_ENH_BIT = 4;
	localparam int USFC_INT_PAUSE = 0;
	localparam int USFC_INT_RESUME = 1;
	// bits that only move while enhanced functions are enabled
	localparam logic [7:0] USFC_IER_ENH_MASK = 8'hf0;
	localparam logic [7:0] USFC_FCR_ENH_MASK = 8'h30;
	localparam logic [7:0] USFC_MCR_ENH_MASK = 8'he0;
	// bus responses
	localparam logic [1:0] USFC_RESP_OKAY = 2'h0;
	localparam logic [1:0] USFC_RESP_SLVERR = 2'h2;
	// receive compare modes
	typedef enum logic [2:0] {USFC_RXM_OFF, USFC_RXM_P1, USFC_RXM_P2, USFC_RXM_AND,
		USFC_RXM_OR} usfc_rxm_t;
	// transmit send modes
	typedef enum logic [1:0] {USFC_TXM_OFF, USFC_TXM_P1, USFC_TXM_P2, USFC_TXM_BOTH} usfc_txm_t;
	// select bits 1:0 and 3:2 to receive mode
	function automatic usfc_rxm_t usfc_rx_mode(input logic [3:0] sel);
		usfc_rxm_t m;
		m = USFC_RXM_OFF;
		unique case (sel[1:0])
			2'h2: m = USFC_RXM_P1;
			2'h1: m = USFC_RXM_P2;
			2'h3: m = (sel[3] == sel[2]) ? USFC_RXM_AND : USFC_RXM_OR;
			2'h0: m = USFC_RXM_OFF;
		endcase
		return m;
	endfunction : usfc_rx_mode
	// select bits 3:2 to transmit mode
	function automatic usfc_txm_t usfc_tx_mode(input logic [3:0] sel);
		usfc_txm_t m;
		m = USFC_TXM_OFF;
		unique case (sel[3:2])
			2'h3: m = USFC_TXM_BOTH;
			2'h2: m = USFC_TXM_P1;
			2'h1: m = USFC_TXM_P2;
			2'h0: m = USFC_TXM_OFF;
		endcase
		return m;
	endfunction : usfc_tx_mode
endpackage : usfc_pkg

// ===== usfc_cfg_if.sv
`timescale 1ns/100ps
// flow control setup handed from the register file to the data path
interface usfc_cfg_if;
	logic [3:0] flow_sel; // select field of the enhanced control register
	logic [7:0] res1; // first resume character
	logic [7:0] res2; // second resume character
	logic [7:0] pau1; // first pause character
	logic [7:0] pau2; // second pause character
	modport ctl (output flow_sel, res1, res2, pau1, pau2);
	modport use_side (input flow_sel, res1, res2, pau1, pau2);
endinterface : usfc_cfg_if

// ===== usfc_rx_match.sv
`timescale 1ns/100ps
// receive compare: strips flow characters, forwards the rest
module usfc_rx_match
	import usfc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// setup
	usfc_cfg_if.use_side cfg,
	// received characters
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	// toward the receive fifo
	output logic out_valid,
	output logic [7:0] out_data,
	// flow events, one cycle each
	output logic pause_evt,
	output logic resume_evt
);
	typedef struct packed {
		logic ready; // input may be taken
		logic pend; // byte waiting for a second pass
		logic [7:0] pend_byte;
		logic hold; // first of a two-character sequence seen
		logic hold_pause; // held byte opens a pause sequence
		logic [7:0] hold_byte;
		logic out_valid;
		logic [7:0] out_data;
		logic pause_evt;
		logic resume_evt;
	} usfc_rxs_t;
	usfc_rxs_t q, d;
	usfc_rxm_t mode;
	logic take;
	logic have;
	logic [7:0] b;
	assign mode = usfc_rx_mode(cfg.flow_sel);
	assign take = in_valid && q.ready;
	assign have = take || q.pend;
	assign b = take ? in_data : q.pend_byte;
	// classify one byte per cycle
	always_comb begin
		d = q;
		d.out_valid = 1'b0;
		d.pause_evt = 1'b0;
		d.resume_evt = 1'b0;
		d.pend = 1'b0;
		if (have) begin
			unique case (mode)
				USFC_RXM_OFF: begin
					d.out_valid = 1'b1;
					d.out_data = b;
				end
				USFC_RXM_P1, USFC_RXM_P2: begin
					if (b == ((mode == USFC_RXM_P1) ? cfg.pau1 : cfg.pau2)) d.pause_evt = 1'b1;
					else if (b == ((mode == USFC_RXM_P1) ? cfg.res1 : cfg.res2)) d.resume_evt = 1'b1;
					else begin
						d.out_valid = 1'b1;
						d.out_data = b;
					end
				end
				USFC_RXM_OR: begin
					if (b == cfg.pau1 || b == cfg.pau2) d.pause_evt = 1'b1;
					else if (b == cfg.res1 || b == cfg.res2) d.resume_evt = 1'b1;
					else begin
						d.out_valid = 1'b1;
						d.out_data = b;
					end
				end
				USFC_RXM_AND: begin
					if (q.hold) begin
						d.hold = 1'b0;
						if (b == (q.hold_pause ? cfg.pau2 : cfg.res2)) begin
							d.pause_evt = q.hold_pause;
							d.resume_evt = !q.hold_pause;
						end else begin
							// broken sequence: release the held byte, retry this one
							d.out_valid = 1'b1;
							d.out_data = q.hold_byte;
							d.pend = 1'b1;
							d.pend_byte = b;
						end
					end else if (b == cfg.pau1 || b == cfg.res1) begin
						d.hold = 1'b1;
						d.hold_pause = (b == cfg.pau1);
						d.hold_byte = b;
					end else begin
						d.out_valid = 1'b1;
						d.out_data = b;
					end
				end
			endcase
		end else if (q.hold && mode != USFC_RXM_AND) begin
			// mode changed under a held byte: pass it on
			d.hold = 1'b0;
			d.out_valid = 1'b1;
			d.out_data = q.hold_byte;
		end
		d.ready = !(take || d.pend);
	end
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) q <= '0;
		else q <= d;
	end
	assign in_ready = q.ready;
	assign out_valid = q.out_valid;
	assign out_data = q.out_data;
	assign pause_evt = q.pause_evt;
	assign resume_evt = q.resume_evt;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_rx_pass_off: assert property (take && mode == USFC_RXM_OFF
		|=> out_valid && out_data == $past(in_data)) else $error("byte not forwarded");
	chk_rx_either_pause: assert property (take && mode == USFC_RXM_OR && in_data == cfg.pau2
		|=> pause_evt && !out_valid) else $error("either pause missed");
	chk_rx_no_forward: assert property ((pause_evt || resume_evt) |-> !out_valid)
		else $error("flow char forwarded");
	cov_rx_pair_seq: cover property (mode == USFC_RXM_AND && q.hold ##[1:20] pause_evt);
endmodule : usfc_rx_match

// ===== usfc_tx_flow.sv
`timescale 1ns/100ps
// sends pause or resume characters as the receive fifo crosses its trigger level
module usfc_tx_flow
	import usfc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// setup
	usfc_cfg_if.use_side cfg,
	// receive fifo at or above trigger level
	input wire logic at_trigger,
	// toward the transmitter
	output logic out_valid,
	output logic [7:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic sent_pause; // far end last told to pause
		logic is_pause; // sequence under way is a pause
		logic second; // second character of the pair on offer
		logic valid;
		logic [7:0] data;
	} usfc_txs_t;
	usfc_txs_t q, d;
	usfc_txm_t mode;
	assign mode = usfc_tx_mode(cfg.flow_sel);
	// sequence one or two characters per level change
	always_comb begin
		d = q;
		if (q.valid) begin
			if (out_ready) begin
				if (mode == USFC_TXM_BOTH && !q.second) begin
					d.second = 1'b1;
					d.data = q.is_pause ? cfg.pau2 : cfg.res2;
				end else begin
					d.valid = 1'b0;
					d.sent_pause = q.is_pause;
				end
			end
		end else if (mode == USFC_TXM_OFF) begin
			d.sent_pause = 1'b0; // nothing sent while disabled
		end else if (at_trigger != q.sent_pause) begin
			d.valid = 1'b1;
			d.is_pause = at_trigger;
			d.second = 1'b0;
			if (mode == USFC_TXM_P2) d.data = at_trigger ? cfg.pau2 : cfg.res2;
			else d.data = at_trigger ? cfg.pau1 : cfg.res1;
		end
	end
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) q <= '0;
		else q <= d;
	end
	assign out_valid = q.valid;
	assign out_data = q.data;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_tx_start_pause: assert property (!q.valid && mode == USFC_TXM_P2 && at_trigger
		&& !q.sent_pause |=> out_valid && out_data == cfg.pau2) else $error("pause not sent");
	chk_tx_hold_char: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("flow char dropped");
	cov_tx_pair_sent: cover property (mode == USFC_TXM_BOTH && out_valid && out_ready
		##[1:50] out_valid && out_ready);
endmodule : usfc_tx_flow

// ===== usfc_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - enhanced enable lets upper control bits change
// - clearing enable freezes the enhanced bits
// - reset clears enhanced bits and enable
// - select 1:0 picks pair, zero disables
// - both-ones select: bits 3:2 pick and/or
// - select 3:2 picks characters transmitted
// - select field resets to zero
// - four character registers, only behind key
// - matched characters dropped, pause or resume interrupt raised
module usfc_top
	import usfc_pkg::*;
#(
	parameter int AXI_AW = 6 // address width
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// received characters from the shift register
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char_data,
	output logic rx_char_ready,
	// characters kept for the receive fifo
	output logic rxf_valid,
	output logic [7:0] rxf_data,
	// receive fifo level at or above trigger
	input wire logic rx_at_trigger,
	// flow characters toward the transmitter
	output logic tx_flow_valid,
	output logic [7:0] tx_flow_data,
	input wire logic tx_flow_ready,
	// transmitter stops at its next character boundary
	output logic tx_suspend,
	// control bits for the rest of the channel
	output logic [7:0] interrupt_enable_bits,
	output logic [7:0] fifo_control_bits,
	output logic [7:0] modem_control_bits,
	output logic [7:0] line_control_bits,
	// interrupt
	output logic irq
);
	// all register and bus state
	typedef struct packed {
		logic aw_have; // write address captured
		logic [3:0] aw_idx;
		logic w_have; // write data captured
		logic [7:0] w_byte;
		logic w_lane0; // low byte lane enabled
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [7:0] interrupt_enable_reg; // interrupt enable bits
		logic [7:0] fifo_control_reg; // fifo control bits
		logic [7:0] line_control_reg; // line control, holds the key
		logic [7:0] modem_control_reg; // modem control bits
		logic [7:0] enhanced_feature_ctrl; // enhanced feature control
		logic [7:0] res1;
		logic [7:0] res2;
		logic [7:0] pau1;
		logic [7:0] pau2;
		logic [1:0] isr; // sticky event bits
		logic [1:0] imr; // interrupt mask, one enables
		logic paused; // far end asked us to stop
		logic irq;
	} usfc_regs_t;
	usfc_regs_t q, d;
	// data path wiring
	usfc_cfg_if cfg ();
	logic pause_evt; // pause sequence recognised
	logic resume_evt; // resume sequence recognised
	logic wr_go; // both halves of a write present
	logic rd_take; // read address taken this cycle
	logic [3:0] ar_idx; // read index
	logic enh; // enhanced functions open

	// an index answers if it exists and, for characters, the key is in place
	function automatic logic usfc_mapped(input logic [3:0] idx, input logic [7:0] line_control_reg);
		logic ok;
		ok = 1'b0;
		unique case (idx)
			USFC_IDX_IER, USFC_IDX_FCR, USFC_IDX_LCR, USFC_IDX_EFR, USFC_IDX_MCR,
			USFC_IDX_ISR, USFC_IDX_IMR, USFC_IDX_STAT: ok = 1'b1;
			USFC_IDX_RES1, USFC_IDX_RES2, USFC_IDX_PAU1, USFC_IDX_PAU2:
				ok = (line_control_reg == USFC_LCR_KEY);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : usfc_mapped

	// write that keeps locked bits when enhanced functions are closed
	function automatic logic [7:0] usfc_merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] lock, input logic open);
		logic [7:0] keep;
		keep = open ? 8'h00 : lock;
		return (old & keep) | (nw & ~keep);
	endfunction : usfc_merge

	assign enh = q.enhanced_feature_ctrl[USFC_EFR_ENH_BIT];
	assign wr_go = q.aw_have && q.w_have && !q.bvalid;
	assign rd_take = s_axi_arvalid && !q.rvalid;
	assign ar_idx = s_axi_araddr[USFC_ADDR_LSB+3:USFC_ADDR_LSB];

	// setup for the compare and send paths
	assign cfg.flow_sel = q.enhanced_feature_ctrl[3:0];
	assign cfg.res1 = q.res1;
	assign cfg.res2 = q.res2;
	assign cfg.pau1 = q.pau1;
	assign cfg.pau2 = q.pau2;

	// next state of bus channels and registers
	always_comb begin
		d = q;
		// capture write address
		if (s_axi_awvalid && !q.aw_have && !q.bvalid) begin
			d.aw_have = 1'b1;
			d.aw_idx = s_axi_awaddr[USFC_ADDR_LSB+3:USFC_ADDR_LSB];
		end
		// capture write data
		if (s_axi_wvalid && !q.w_have && !q.bvalid) begin
			d.w_have = 1'b1;
			d.w_byte = s_axi_wdata[7:0];
			d.w_lane0 = s_axi_wstrb[0];
		end
		// retire the response
		if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
		// perform the write once both halves are in
		if (wr_go) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = usfc_mapped(q.aw_idx, q.line_control_reg) ? USFC_RESP_OKAY : USFC_RESP_SLVERR;
			if (q.w_lane0 && usfc_mapped(q.aw_idx, q.line_control_reg)) begin
				unique case (q.aw_idx)
					USFC_IDX_IER: d.interrupt_enable_reg = usfc_merge(q.interrupt_enable_reg, q.w_byte, USFC_IER_ENH_MASK, enh);
					USFC_IDX_FCR: d.fifo_control_reg = usfc_merge(q.fifo_control_reg, q.w_byte, USFC_FCR_ENH_MASK, enh);
					USFC_IDX_MCR: d.modem_control_reg = usfc_merge(q.modem_control_reg, q.w_byte, USFC_MCR_ENH_MASK, enh);
					USFC_IDX_LCR: d.line_control_reg = q.w_byte;
					USFC_IDX_EFR: d.enhanced_feature_ctrl = q.w_byte;
					USFC_IDX_RES1: d.res1 = q.w_byte;
					USFC_IDX_RES2: d.res2 = q.w_byte;
					USFC_IDX_PAU1: d.pau1 = q.w_byte;
					USFC_IDX_PAU2: d.pau2 = q.w_byte;
					USFC_IDX_IMR: d.imr = q.w_byte[1:0];
					USFC_IDX_ISR: d.isr = q.isr & ~q.w_byte[1:0]; // write one clears
					default: d.bresp = USFC_RESP_OKAY; // status ignores writes
				endcase
			end
		end
		// read channel
		if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
		if (rd_take) begin
			d.rvalid = 1'b1;
			d.rresp = usfc_mapped(ar_idx, q.line_control_reg) ? USFC_RESP_OKAY : USFC_RESP_SLVERR;
			d.rdata = USFC_RST_BYTE;
			if (usfc_mapped(ar_idx, q.line_control_reg)) begin
				unique case (ar_idx)
					USFC_IDX_IER: d.rdata = q.interrupt_enable_reg;
					USFC_IDX_FCR: d.rdata = q.fifo_control_reg;
					USFC_IDX_LCR: d.rdata = q.line_control_reg;
					USFC_IDX_MCR: d.rdata = q.modem_control_reg;
					USFC_IDX_EFR: d.rdata = q.enhanced_feature_ctrl;
					USFC_IDX_RES1: d.rdata = q.res1;
					USFC_IDX_RES2: d.rdata = q.res2;
					USFC_IDX_PAU1: d.rdata = q.pau1;
					USFC_IDX_PAU2: d.rdata = q.pau2;
					USFC_IDX_ISR: d.rdata = {6'h00, q.isr};
					USFC_IDX_IMR: d.rdata = {6'h00, q.imr};
					default: d.rdata = {7'h00, q.paused};
				endcase
			end
		end
		// events set their sticky bits; a set beats a clear in the same cycle
		if (pause_evt) d.isr[USFC_INT_PAUSE] = 1'b1;
		if (resume_evt) d.isr[USFC_INT_RESUME] = 1'b1;
		// transmitter hold follows the last flow event
		if (pause_evt) d.paused = 1'b1;
		else if (resume_evt) d.paused = 1'b0;
		d.irq = |(d.isr & d.imr);
	end

	// register stage; reset clears every control bit and the select field
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.interrupt_enable_reg <= USFC_RST_BYTE;
			q.enhanced_feature_ctrl <= USFC_RST_BYTE;
			q.isr <= USFC_RST_INT;
		end else begin
			q <= d;
		end
	end

	// receive compare path
	usfc_rx_match u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(cfg.use_side),
		.in_valid(rx_char_valid),
		.in_data(rx_char_data),
		.in_ready(rx_char_ready),
		.out_valid(rxf_valid),
		.out_data(rxf_data),
		.pause_evt(pause_evt),
		.resume_evt(resume_evt)
	);

	// flow character sender
	usfc_tx_flow u_tx (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(cfg.use_side),
		.at_trigger(rx_at_trigger),
		.out_valid(tx_flow_valid),
		.out_data(tx_flow_data),
		.out_ready(tx_flow_ready)
	);

	// outputs straight from the register stage
	assign s_axi_awready = !q.aw_have && !q.bvalid;
	assign s_axi_wready = !q.w_have && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = {24'h000000, q.rdata};
	assign s_axi_rresp = q.rresp;
	assign tx_suspend = q.paused;
	assign interrupt_enable_bits = q.interrupt_enable_reg;
	assign fifo_control_bits = q.fifo_control_reg;
	assign modem_control_bits = q.modem_control_reg;
	assign line_control_bits = q.line_control_reg;
	assign irq = q.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// open enhanced bits take the written value
	chk_enh_write_ier: assert property (wr_go && q.w_lane0 && q.aw_idx == USFC_IDX_IER && enh
		|=> q.interrupt_enable_reg == $past(q.w_byte)) else $error("ier upper bits not written");
	// closed enhanced bits of mcr and ier stay frozen across any write
	chk_enh_lock_mcr: assert property (!enh |=> q.modem_control_reg[7:5] == $past(q.modem_control_reg[7:5]))
		else $error("locked mcr bits moved");
	chk_enh_lock_ier: assert property (!enh |=> q.interrupt_enable_reg[7:4] == $past(q.interrupt_enable_reg[7:4]))
		else $error("locked ier bits moved");
	// clean state at reset release
	chk_reset_clear: assert property ($rose(aresetn) |-> q.interrupt_enable_reg == 8'h00 && q.fifo_control_reg == 8'h00
		&& q.modem_control_reg == 8'h00 && !enh) else $error("enhanced bits not cleared");
	chk_sel_default: assert property ($rose(aresetn) |-> q.enhanced_feature_ctrl[3:0] == 4'h0 && !tx_flow_valid
		&& !tx_suspend) else $error("select not zero after reset");
	// characters hidden without the key
	chk_char_gate: assert property (wr_go && q.aw_idx == USFC_IDX_PAU1 && q.line_control_reg != USFC_LCR_KEY
		|=> $stable(q.pau1) && s_axi_bresp == USFC_RESP_SLVERR)
		else $error("character written without key");
	// pause event raises the sticky bit and, if unmasked, the line
	chk_pause_irq: assert property (pause_evt && q.imr[USFC_INT_PAUSE]
		|=> q.isr[USFC_INT_PAUSE] ##1 irq) else $error("pause interrupt missing");
	// suspend follows pause and lifts on resume
	chk_suspend_set: assert property (pause_evt |=> tx_suspend)
		else $error("transmitter not suspended");
	chk_suspend_clear: assert property (resume_evt && !pause_evt |=> !tx_suspend)
		else $error("transmitter not released");
	// main scenarios
	cov_pause_resume: cover property (pause_evt ##[1:200] resume_evt);
	cov_irq_clear: cover property (irq ##[1:50] !irq);
	cov_char_write: cover property (wr_go && q.aw_idx == USFC_IDX_RES1 && q.line_control_reg == USFC_LCR_KEY);
endmodule : usfc_top

// ===== usfc_remote.sv
`timescale 1ns/100ps
// far station: feeds received characters, sinks flow characters
module usfc_remote (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// sink pacing
	input wire logic slow,
	// characters into the receiver
	output logic rx_char_valid,
	output logic [7:0] rx_char_data,
	input wire logic rx_char_ready,
	// flow characters from the transmitter
	input wire logic tx_flow_valid,
	input wire logic [7:0] tx_flow_data,
	output logic tx_flow_ready
);
	logic [7:0] got_q[$]; // flow characters taken
	initial begin
		rx_char_valid = 1'b0;
		rx_char_data = 8'h00;
		tx_flow_ready = 1'b0;
	end
	// sink: prompt, or ready every other cycle when slow
	always @(posedge aclk) begin
		if (tx_flow_valid && tx_flow_ready) got_q.push_back(tx_flow_data);
		tx_flow_ready <= slow ? (tx_flow_valid && !tx_flow_ready) : aresetn;
	end
	// one character, held until taken, then the line shows its inverse
	task automatic send(input logic [7:0] c);
		@(posedge aclk);
		rx_char_valid <= 1'b1;
		rx_char_data <= c;
		do @(posedge aclk); while (rx_char_ready !== 1'b1);
		rx_char_valid <= 1'b0;
		rx_char_data <= ~c;
		repeat (6) @(posedge aclk);
	endtask : send
endmodule : usfc_remote

// ===== tb.sv
`timescale 1ns/100ps
// bench for the flow control setup block
module tb;
	import usfc_pkg::*;
	localparam logic [1:0] OK = USFC_RESP_OKAY;
	localparam logic [1:0] SE = USFC_RESP_SLVERR;
	// register access row
	typedef struct packed {logic [3:0] idx; logic [7:0] wd; logic [1:0] wr; logic [7:0] rd;
		logic [1:0] rr;} usfc_tb_reg_t;
	// received character row
	typedef struct packed {logic [7:0] enhanced_feature_ctrl; logic [7:0] ch; logic [1:0] fwd;
		logic susp;} usfc_tb_rx_t;
	logic aclk, aresetn, slow, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, rxv, rxr, rxfv, trig, txv, txr, susp, irq;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] rxd, rxfd, txd, interrupt_enable_reg, fifo_control_reg, modem_control_reg, line_control_reg, rxf_last;
	logic [7:0] ex[$];
	int error_cnt, samples_checked, cyc, rxf_n, n0;
	usfc_tb_reg_t regs [17] = '{'{4'h3, 8'hbf, OK, 8'hbf, OK}, '{4'h4, 8'h11, OK, 8'h11, OK},
		'{4'h5, 8'h12, OK, 8'h12, OK}, '{4'h6, 8'h13, OK, 8'h13, OK},
		'{4'h7, 8'h14, OK, 8'h14, OK}, '{4'h8, 8'h10, OK, 8'h10, OK},
		'{4'h1, 8'hff, OK, 8'hff, OK}, '{4'h9, 8'he0, OK, 8'he0, OK},
		'{4'h2, 8'h3f, OK, 8'h3f, OK},
		'{4'h8, 8'h0a, OK, 8'h0a, OK}, '{4'h1, 8'h00, OK, 8'hf0, OK},
		'{4'h9, 8'h00, OK, 8'he0, OK}, '{4'h2, 8'h0c, OK, 8'h3c, OK},
		'{4'hf, 8'h5a, SE, 8'h00, SE},
		'{4'h3, 8'h00, OK, 8'h00, OK}, '{4'h6, 8'h77, SE, 8'h00, SE},
		'{4'hb, 8'h01, OK, 8'h01, OK}};
	usfc_tb_rx_t rxt [18] = '{'{8'h0a, 8'h55, 1, 0}, '{8'h0a, 8'h13, 0, 1}, '{8'h0a, 8'h14, 1, 1},
		'{8'h0a, 8'h11, 0, 0}, '{8'h05, 8'h13, 1, 0}, '{8'h05, 8'h14, 0, 1},
		'{8'h05, 8'h12, 0, 0}, '{8'h07, 8'h14, 0, 1}, '{8'h07, 8'h11, 0, 0},
		'{8'h0b, 8'h13, 0, 1}, '{8'h0b, 8'h12, 0, 0}, '{8'h0f, 8'h13, 0, 0},
		'{8'h0f, 8'h14, 0, 1}, '{8'h0f, 8'h11, 0, 1}, '{8'h0f, 8'h12, 0, 0},
		'{8'h0f, 8'h13, 0, 0}, '{8'h0f, 8'h55, 2, 0}, '{8'h0c, 8'h13, 1, 0}};
	usfc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_char_valid(rxv), .rx_char_data(rxd), .rx_char_ready(rxr), .rxf_valid(rxfv),
		.rxf_data(rxfd), .rx_at_trigger(trig), .tx_flow_valid(txv), .tx_flow_data(txd),
		.tx_flow_ready(txr), .tx_suspend(susp), .interrupt_enable_bits(interrupt_enable_reg),
		.fifo_control_bits(fifo_control_reg), .modem_control_bits(modem_control_reg), .line_control_bits(line_control_reg), .irq(irq));
	usfc_remote u_rem (.aclk(aclk), .aresetn(aresetn), .slow(slow), .rx_char_valid(rxv),
		.rx_char_data(rxd), .rx_char_ready(rxr), .tx_flow_valid(txv), .tx_flow_data(txd),
		.tx_flow_ready(txr));
	// clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// kept-character monitor and hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (rxfv === 1'b1) rxf_n <= rxf_n + 1;
		if (rxfv === 1'b1) rxf_last <= rxfd;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// bus write; address and data released as each is taken
	task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				done = 1'b1;
				bready <= 1'b0;
				chk("bresp", {30'h0, er}, {30'h0, bresp});
			end
		end
	endtask : wr
	// bus read and compare
	task automatic rd(input logic [3:0] idx, input logic [7:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		chk("rdata", {24'h0, ed}, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge aclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : chk_irq
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// main sequence
	initial begin
		{aresetn, slow, awvalid, wvalid, bready, arvalid, rready, trig} = 8'h00;
		{awaddr, araddr, wdata, wstrb} = {12'h000, 32'h0, 4'h1};
		{error_cnt, samples_checked, cyc, rxf_n} = {32'h0, 32'h0, 32'h0, 32'h0};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (regs[i]) begin
			wr(regs[i].idx, regs[i].wd, regs[i].wr);
			rd(regs[i].idx, regs[i].rd, regs[i].rr);
		end
		chk("ier out", 8'hf0, interrupt_enable_reg);
		chk("mcr out", 8'he0, modem_control_reg);
		chk("fcr out", 8'h3c, fifo_control_reg);
		chk("lcr out", 8'h00, line_control_reg);
		$display("test registers done");
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("ier rst", 8'h00, interrupt_enable_reg);
		chk("fcr rst", 8'h00, fifo_control_reg);
		chk("mcr rst", 8'h00, modem_control_reg);
		rd(4'h8, 8'h00, OK);
		wr(4'h3, 8'hbf, OK);
		rd(4'h7, 8'h00, OK);
		for (int k = 4; k < 8; k++) wr(4'(k), 8'(13 + k), OK);
		wr(4'hb, 8'h01, OK);
		$display("test reset done");
		foreach (rxt[i]) begin
			n0 = rxf_n;
			if (i == 0 || rxt[i].enhanced_feature_ctrl != rxt[i - 1].enhanced_feature_ctrl) wr(4'h8, rxt[i].enhanced_feature_ctrl, OK);
			u_rem.send(rxt[i].ch);
			chk("kept count", {30'h0, rxt[i].fwd}, 32'(rxf_n - n0));
			if (rxt[i].fwd == 2'd1) chk("kept char", {24'h0, rxt[i].ch}, {24'h0, rxf_last});
			chk("suspend", {31'h0, rxt[i].susp}, {31'h0, susp});
		end
		$display("test receive done");
		chk_irq(1'b1);
		wr(4'hb, 8'h00, OK);
		chk_irq(1'b0);
		wr(4'hb, 8'h01, OK);
		rd(4'ha, 8'h03, OK);
		rd(4'hc, 8'h00, OK);
		wr(4'ha, 8'h03, OK);
		chk_irq(1'b0);
		rd(4'ha, 8'h00, OK);
		// low byte lane off: response given, nothing stored
		wstrb <= 4'h0;
		wr(4'h3, 8'h55, OK);
		wstrb <= 4'h1;
		chk("lcr nostrb", 8'hbf, line_control_reg);
		$display("test interrupt done");
		for (int m = 3; m >= 0; m--) begin
			wr(4'h8, {4'h0, 2'(m), 2'b00}, OK);
			slow <= (m == 3);
			u_rem.got_q.delete();
			trig <= 1'b1;
			repeat (12) @(posedge aclk);
			trig <= 1'b0;
			repeat (12) @(posedge aclk);
			ex = {};
			if (m[1]) ex.push_back(8'h13);
			if (m[0]) ex.push_back(8'h14);
			if (m[1]) ex.push_back(8'h11);
			if (m[0]) ex.push_back(8'h12);
			chk("tx count", 32'(ex.size()), 32'(u_rem.got_q.size()));
			foreach (ex[j]) chk("tx char", {24'h0, ex[j]}, {24'h0, u_rem.got_q[j]});
		end
		$display("test transmit done");
		finish_test();
	end
endmodule : tb
